// >>> uesf_top.sv
// usb event status flags with mask, control and axi4-lite register access
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "uesf_cfg.svh"
module uesf_top
  import uesf_pkg::*;
#(
  parameter int PSEUDO_PERIOD = `UESF_PSEUDO_CYCLES
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // axi4-lite write address and data
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // event pins from the usb engine, asynchronous
  input  wire logic        BUS_RESET_DET,
  input  wire logic        SUSPEND_DET,
  input  wire logic        RESUME_DET,
  input  wire logic        FRAME_DET,
  input  wire logic        SETUP_DONE_DET,
  input  wire logic        SETUP_OVERWRITE_DET,
  input  wire logic        FRAME_LOCKED,
  // resets, controls and interrupt
  output logic             USB_LOGIC_RESET,
  output logic             CHIP_LOGIC_RESET,
  output logic             RESET_OUTPUT_PIN,
  output logic             BUS_CONNECT,
  output logic             SHADOW_ROM,
  output logic             IRQ
);
  // synchronised event levels
  logic [6:0] raw_w;
  logic [6:0] lvl;
  logic [6:0] lvl_d_r;
  assign raw_w = {BUS_RESET_DET, SUSPEND_DET, RESUME_DET, FRAME_DET,
                  SETUP_DONE_DET, SETUP_OVERWRITE_DET, FRAME_LOCKED};
  for (genvar i = 0; i < 7; i++) begin : g_sync
    uesf_sync u_sync (
      .clk   (CLK),
      .rst_n (RST_N),
      .d     (raw_w[i]),
      .q     (lvl[i])
    );
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) lvl_d_r <= 7'h00;
    else        lvl_d_r <= lvl;
  end
  wire [6:0] rise       = lvl & ~lvl_d_r;
  wire       rst_rise   = rise[6];
  wire       locked     = lvl[0];
  wire       frame_rise = rise[3];
  logic      pseudo_tick;

  uesf_pseudo_timer #(
    .PERIOD (PSEUDO_PERIOD)
  ) u_pseudo (
    .clk    (CLK),
    .rst_n  (RST_N),
    .clear  (frame_rise || rst_rise),
    .locked (locked),
    .tick   (pseudo_tick)
  );

  // registers
  uesf_byte_t status_r;
  uesf_byte_t status_nxt;
  uesf_byte_t mask_r;
  uesf_byte_t ctrl_r;
  // propagated reset on a bus reset while the propagate bit is set; scrubs the mask only, controls are kept
  wire        propagate = ctrl_r[`UESF_BIT_PROPAGATE];
  wire        chip_rst  = rst_rise && propagate;

  // axi write path: address and data accepted in either order
  logic       aw_hold_r;
  logic       w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  wire        aw_take  = S_AXI_AWVALID && S_AXI_AWREADY;
  wire        w_take   = S_AXI_WVALID && S_AXI_WREADY;
  wire        aw_have  = aw_hold_r || aw_take;
  wire        w_have   = w_hold_r || w_take;
  wire [7:0]  wr_addr  = aw_hold_r ? awaddr_r : S_AXI_AWADDR;
  wire [31:0] wr_data  = w_hold_r ? wdata_r : S_AXI_WDATA;
  wire [3:0]  wr_strb  = w_hold_r ? wstrb_r : S_AXI_WSTRB;
  wire        wr_fire  = aw_have && w_have && !S_AXI_BVALID;
  wire        wr_mask  = wr_fire && (wr_addr == `UESF_OFS_MASK);
  wire        wr_ctrl  = wr_fire && (wr_addr == `UESF_OFS_CONTROL);
  wire        wr_vec   = wr_fire && (wr_addr == `UESF_OFS_VECTOR);
  wire        wr_stat  = wr_fire && (wr_addr == `UESF_OFS_STATUS);
  wire        wr_known = wr_mask || wr_ctrl || wr_vec || wr_stat;
  // any write to the vector register clears the flags, data ignored
  wire        flag_clr = wr_vec;

  // event set vector
  uesf_byte_t set_w;
  assign set_w = {rst_rise,
                  rise[5],
                  rise[4],
                  frame_rise,
                  pseudo_tick,
                  rise[2],
                  1'b0,
                  rise[1]};
  // set wins over clear so a coincident event is not lost
  assign status_nxt = ((flag_clr ? `UESF_RESET_BYTE : status_r) | set_w)
                      & `UESF_FLAG_MASK;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) status_r <= `UESF_RESET_BYTE;
    else        status_r <= status_nxt;
  end

  uesf_byte_t mask_nxt;
  uesf_byte_t ctrl_nxt;
  assign mask_nxt = chip_rst ? `UESF_RESET_BYTE :
                    (wr_mask && wr_strb[0]) ? (wr_data[7:0] & `UESF_FLAG_MASK) : mask_r;
  // connect and shadow bits survive a propagated reset, propagate bit is kept too
  assign ctrl_nxt = (wr_ctrl && wr_strb[0]) ? (wr_data[7:0] & `UESF_CTRL_MASK) : ctrl_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_r <= `UESF_RESET_BYTE;
      ctrl_r <= `UESF_RESET_BYTE;
    end else begin
      mask_r <= mask_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'b00;
    end else begin
      if (aw_take) awaddr_r <= S_AXI_AWADDR;
      if (w_take) begin
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      aw_hold_r <= aw_have && !wr_fire;
      w_hold_r  <= w_have && !wr_fire;
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        // status is read-only: writes to it are refused
        S_AXI_BRESP  <= (wr_known && !wr_stat) ? 2'b00 : 2'b10;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end
  assign S_AXI_AWREADY = !aw_hold_r && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_hold_r && !S_AXI_BVALID;

  // axi read path
  wire        ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire        rd_stat = (S_AXI_ARADDR == `UESF_OFS_STATUS);
  wire        rd_mask = (S_AXI_ARADDR == `UESF_OFS_MASK);
  wire        rd_ctrl = (S_AXI_ARADDR == `UESF_OFS_CONTROL);
  wire        rd_vec  = (S_AXI_ARADDR == `UESF_OFS_VECTOR);
  wire [7:0]  rd_byte = rd_stat ? status_r :
                        rd_mask ? mask_r :
                        rd_ctrl ? ctrl_r : 8'h00;
  wire        rd_ok   = rd_stat || rd_mask || rd_ctrl || rd_vec;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= 2'b00;
    end else if (ar_take) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= {24'h00_0000, rd_byte};
      S_AXI_RRESP  <= rd_ok ? 2'b00 : 2'b10;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // reset, control and interrupt outputs, all registered
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      USB_LOGIC_RESET  <= 1'b0;
      CHIP_LOGIC_RESET <= 1'b0;
      RESET_OUTPUT_PIN <= 1'b0;
      BUS_CONNECT      <= 1'b0;
      SHADOW_ROM       <= 1'b0;
      IRQ              <= 1'b0;
    end else begin
      USB_LOGIC_RESET  <= lvl[6];
      CHIP_LOGIC_RESET <= lvl[6] && propagate;
      RESET_OUTPUT_PIN <= lvl[6] && propagate;
      BUS_CONNECT      <= ctrl_nxt[`UESF_BIT_CONNECT];
      SHADOW_ROM       <= ctrl_nxt[`UESF_BIT_SHADOW];
      IRQ              <= |(status_nxt & mask_nxt);
    end
  end
endmodule

// >>> uesf_cfg.svh
// register offsets, bit positions, reset values and timing counts for the event flag block
`ifndef UESF_CFG_SVH
`define UESF_CFG_SVH
`define UESF_OFS_STATUS      8'h00
`define UESF_OFS_MASK        8'h04
`define UESF_OFS_CONTROL     8'h08
`define UESF_OFS_VECTOR      8'h0C
`define UESF_BIT_BUS_RESET   7
`define UESF_BIT_SUSPEND     6
`define UESF_BIT_RESUME      5
`define UESF_BIT_FRAME       4
`define UESF_BIT_PSEUDO      3
`define UESF_BIT_SETUP       2
`define UESF_BIT_RESERVED    1
`define UESF_BIT_OVERWRITE   0
`define UESF_BIT_CONNECT     7
`define UESF_BIT_PROPAGATE   4
`define UESF_BIT_SHADOW      0
`define UESF_FLAG_MASK       8'hFD
`define UESF_CTRL_MASK       8'h91
`define UESF_RESET_BYTE      8'h00
`define UESF_CLK_MHZ         200
`define UESF_PSEUDO_US       1000
`define UESF_PSEUDO_CYCLES   (`UESF_PSEUDO_US * `UESF_CLK_MHZ)
`endif

// >>> uesf_pkg.sv
// types shared by the event flag block
package uesf_pkg;
  typedef logic [7:0] uesf_byte_t;
  typedef enum logic [2:0] {
    UESF_IDLE = 3'b001,
    UESF_DATA = 3'b010,
    UESF_RESP = 3'b100
  } uesf_wr_e;
endpackage

// >>> uesf_sync.sv
// two-flop synchroniser for one level input
`timescale 1ns/1ps
module uesf_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // level in and out
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// >>> uesf_pseudo_timer.sv
// free-running frame-start generator used while the frame timer is unlocked
`timescale 1ns/1ps
`include "uesf_cfg.svh"
module uesf_pseudo_timer #(
  parameter int PERIOD = `UESF_PSEUDO_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic clear,
  input  wire logic locked,
  // event
  output logic      tick
);
  localparam logic [31:0] LAST = 32'(PERIOD - 1);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  wire         at_end = (cnt_r >= LAST);
  // restarts on a real frame so pseudo events keep the host rhythm once unlocked
  assign cnt_nxt = (clear || at_end) ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= at_end && !clear && !locked;
    end
  end
endmodule

// >>> uesf_properties.sv
// concurrent checks on the event flag block's ports
`timescale 1ns/1ps
module uesf_properties (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // register bus
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  // bus reset and reset outputs
  input wire logic        BUS_RESET_DET,
  input wire logic        USB_LOGIC_RESET,
  input wire logic        CHIP_LOGIC_RESET,
  input wire logic        RESET_OUTPUT_PIN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire wr_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  wire rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  a_pin_follows_chip: assert property (RESET_OUTPUT_PIN == CHIP_LOGIC_RESET)
    else $error("reset pin differs from chip reset");
  a_chip_needs_usb: assert property (CHIP_LOGIC_RESET |-> USB_LOGIC_RESET)
    else $error("chip reset without usb reset");
  a_usb_reset_on: assert property ($rose(BUS_RESET_DET) |-> ##[1:5] USB_LOGIC_RESET)
    else $error("usb logic reset missing");
  a_usb_reset_off: assert property (!BUS_RESET_DET [*6] |-> !USB_LOGIC_RESET)
    else $error("usb logic reset stuck");
  a_status_write_err: assert property (wr_take && S_AXI_AWADDR == 8'h00 |=>
    S_AXI_BVALID && S_AXI_BRESP == 2'b10) else $error("status write accepted");
  a_rdata_unused_zero: assert property (S_AXI_RVALID |->
    S_AXI_RDATA[31:8] == 24'h00_0000 && !S_AXI_RDATA[1]) else $error("unused read bits set");
  a_write_answer: assert property (wr_take |=> S_AXI_BVALID)
    else $error("write response missing");
  a_read_answer: assert property (rd_take |=> S_AXI_RVALID)
    else $error("read response missing");
  cover property ($rose(RESET_OUTPUT_PIN));
  cover property (wr_take && S_AXI_AWADDR == 8'h0C);
  cover property ($rose(USB_LOGIC_RESET));
endmodule

// >>> uesf_usb_model.sv
// far-side usb engine model: drives one event pin as a level pulse
`timescale 1ns/1ps
module uesf_usb_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // command
  input  wire logic       go,
  input  wire logic [2:0] sel,
  // event pins
  output logic [5:0]      pins
);
  logic [2:0] cnt_r;
  logic [2:0] sel_r;
  // six cycles high so the two-flop synchroniser cannot miss the edge
  assign pins = (cnt_r != 3'h0) ? (6'h01 << sel_r) : 6'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      sel_r <= 3'h0;
    end else if (go) begin
      cnt_r <= 3'h6;
      sel_r <= sel;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
endmodule

// >>> tb_usb_event_status_flags.sv
// self-checking bench for the usb event status flag block
`timescale 1ns/1ps
module tb_usb_event_status_flags;
  logic        CLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, FRAME_LOCKED, ev_go;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA;
  logic [2:0]  ev_sel;
  logic [5:0]  ev_pins;
  wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ;
  wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  wire  [31:0] S_AXI_RDATA;
  wire         USB_LOGIC_RESET, CHIP_LOGIC_RESET, RESET_OUTPUT_PIN, BUS_CONNECT, SHADOW_ROM;
  int          bad_count, checks_done;
  logic [7:0]  ev_bit [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h01};
  uesf_top #(.PSEUDO_PERIOD(50)) DUT (
    .CLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB(4'h1), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY(1'b1), .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY(1'b1), .BUS_RESET_DET(ev_pins[0]),
    .SUSPEND_DET(ev_pins[1]), .RESUME_DET(ev_pins[2]), .FRAME_DET(ev_pins[3]),
    .SETUP_DONE_DET(ev_pins[4]), .SETUP_OVERWRITE_DET(ev_pins[5]), .FRAME_LOCKED,
    .USB_LOGIC_RESET, .CHIP_LOGIC_RESET, .RESET_OUTPUT_PIN, .BUS_CONNECT, .SHADOW_ROM, .IRQ);
  uesf_usb_model far (.clk(CLK), .rst_n(RST_N), .go(ev_go), .sel(ev_sel), .pins(ev_pins));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    cmp(32'(got), 32'(exp));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge CLK);
      if (S_AXI_AWREADY) aw_ok = 1'b1;
      if (S_AXI_WREADY) w_ok = 1'b1;
      if (aw_ok) S_AXI_AWVALID <= 1'b0;
      if (w_ok) S_AXI_WVALID <= 1'b0;
    end
    do @(posedge CLK); while (!S_AXI_BVALID);
    cmp(32'(S_AXI_BRESP), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do @(posedge CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK); while (!S_AXI_RVALID);
    cmp(S_AXI_RDATA, ed);
    cmp(32'(S_AXI_RRESP), 32'(er));
  endtask
  task automatic fire(input logic [2:0] s, input int n);
    ev_sel <= s;
    ev_go <= 1'b1;
    @(posedge CLK);
    ev_go <= 1'b0;
    repeat (n) @(posedge CLK);
  endtask
  task print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge CLK);
    bad_count++;
    print_verdict;
  end
  initial begin
    {RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, ev_go} = 5'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, ev_sel} = 19'h0_0000;
    S_AXI_WDATA = 32'h0000_0000;
    FRAME_LOCKED = 1'b1;
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    rd(8'h00, 32'h0000_0000, 2'b00);
    rd(8'h04, 32'h0000_0000, 2'b00);
    rd(8'h10, 32'h0000_0000, 2'b10);
    wr(8'h00, 32'h0000_00FF, 2'b10);
    rd(8'h00, 32'h0000_0000, 2'b00);
    $display("test reset and access done");
    for (int i = 0; i < 6; i++) begin
      fire(3'(i), 10);
      rd(8'h00, 32'(ev_bit[i]), 2'b00);
      wr(8'h0C, 32'h0000_0000, 2'b00);
      rd(8'h00, 32'h0000_0000, 2'b00);
    end
    $display("test event flags done");
    wr(8'h04, 32'h0000_0040, 2'b00);
    fire(3'h2, 10);
    cmp_pin(IRQ, 1'b0);
    fire(3'h1, 10);
    cmp_pin(IRQ, 1'b1);
    wr(8'h0C, 32'h0000_0000, 2'b00);
    @(posedge CLK);
    cmp_pin(IRQ, 1'b0);
    wr(8'h04, 32'h0000_0000, 2'b00);
    $display("test interrupt mask done");
    fire(3'h3, 10);
    FRAME_LOCKED <= 1'b0;
    rd(8'h00, 32'h0000_0010, 2'b00);
    wr(8'h0C, 32'h0000_0000, 2'b00);
    repeat (20) @(posedge CLK);
    rd(8'h00, 32'h0000_0000, 2'b00);
    repeat (20) @(posedge CLK);
    rd(8'h00, 32'h0000_0008, 2'b00);
    FRAME_LOCKED <= 1'b1;
    repeat (4) @(posedge CLK);
    wr(8'h0C, 32'h0000_0000, 2'b00);
    repeat (60) @(posedge CLK);
    rd(8'h00, 32'h0000_0000, 2'b00);
    $display("test pseudo frame done");
    wr(8'h08, 32'h0000_00FF, 2'b00);
    rd(8'h08, 32'h0000_0091, 2'b00);
    wr(8'h04, 32'h0000_00FF, 2'b00);
    rd(8'h04, 32'h0000_00FD, 2'b00);
    fire(3'h0, 5);
    cmp_pin(RESET_OUTPUT_PIN, 1'b1);
    cmp_pin(USB_LOGIC_RESET, 1'b1);
    cmp_pin(CHIP_LOGIC_RESET, 1'b1);
    repeat (8) @(posedge CLK);
    rd(8'h04, 32'h0000_0000, 2'b00);
    rd(8'h08, 32'h0000_0091, 2'b00);
    cmp_pin(BUS_CONNECT, 1'b1);
    cmp_pin(SHADOW_ROM, 1'b1);
    $display("test reset propagation done");
    print_verdict;
  end
endmodule
bind uesf_top uesf_properties chk (
  .CLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
  .BUS_RESET_DET, .USB_LOGIC_RESET, .CHIP_LOGIC_RESET, .RESET_OUTPUT_PIN);
